/* src/ipgac_pkg.sv */
// package of offsets, fields, reset values and types for the input gain config registers
package ipgac_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IPGAC_IDX_RGAIN  = 8'h2d;
  localparam logic [7:0] IPGAC_IDX_LROUTE = 8'h2e;
  localparam logic [7:0] IPGAC_IDX_RMODE  = 8'h2f;   // right mode holder
  localparam int         IPGAC_ADDR_W     = 12;
  localparam logic [IPGAC_ADDR_W-1:0] IPGAC_ADDR_RGAIN  = {2'h0, IPGAC_IDX_RGAIN, 2'h0};
  localparam logic [IPGAC_ADDR_W-1:0] IPGAC_ADDR_LROUTE = {2'h0, IPGAC_IDX_LROUTE, 2'h0};
  localparam logic [IPGAC_ADDR_W-1:0] IPGAC_ADDR_RMODE  = {2'h0, IPGAC_IDX_RMODE, 2'h0};

  // field positions
  localparam int IPGAC_MUTE_BIT  = 7;
  localparam int IPGAC_GAIN_LSB  = 0;
  localparam int IPGAC_GAIN_W    = 5;
  localparam int IPGAC_CMR_BIT   = 6;
  localparam int IPGAC_NSEL_LSB  = 4;
  localparam int IPGAC_PSEL_LSB  = 2;
  localparam int IPGAC_MODE_LSB  = 0;

  // reset values
  localparam logic       IPGAC_MUTE_RST = 1'b1;
  localparam logic [4:0] IPGAC_GAIN_RST = 5'h05;
  localparam logic       IPGAC_CMR_RST  = 1'b1;
  localparam logic [1:0] IPGAC_NSEL_RST = 2'h0;
  localparam logic [1:0] IPGAC_PSEL_RST = 2'h1;
  localparam logic [1:0] IPGAC_MODE_RST = 2'h0;

  // mode encoding, shared by both channels
  localparam logic [1:0] IPGAC_MODE_SE   = 2'h0;
  localparam logic [1:0] IPGAC_MODE_DLIN = 2'h1;
  localparam logic [1:0] IPGAC_MODE_DMIC = 2'h2;

  // axi responses
  localparam logic [1:0] IPGAC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] IPGAC_RESP_SLVERR = 2'h2;

  // gain in tenths of a dB, signed
  typedef logic signed [9:0] ipgac_gain_t;

  // pin choice one-hot: a, b, c
  typedef logic [2:0] ipgac_pin_t;

  // analogue control bundle of the left channel
  typedef struct packed {
    ipgac_pin_t invPin;   // pin on the inverting side
    ipgac_pin_t nonPin;   // pin on the non-inverting side
    logic       cmRejectOn;
    logic [1:0] mode;
  } ipgac_left_ctl_t;

  // analogue control bundle of the right channel gain stage
  typedef struct packed {
    logic        silence;
    ipgac_gain_t gainTenths;
    logic        gainValid;   // low for a reserved code
  } ipgac_right_ctl_t;

endpackage

/* src/ipgac_gain_map.sv */
// gain code to tenths of a dB, per input mode
`timescale 1ns/1ps
module ipgac_gain_map
  import ipgac_pkg::*;
(
  // code and mode
  input  wire logic [4:0]  code,
  input  wire logic [1:0]  mode,
  // decoded gain
  output ipgac_gain_t      gainTenths,
  output logic             gainValid
);

  // line table, non-uniform steps
  localparam logic signed [9:0] LINE_TAB [32] = '{
    -10'sd15, -10'sd13, -10'sd10, -10'sd7, -10'sd3, 10'sd0, 10'sd3, 10'sd7,
    10'sd10, 10'sd14, 10'sd18, 10'sd23, 10'sd27, 10'sd32, 10'sd37, 10'sd42,
    10'sd48, 10'sd54, 10'sd60, 10'sd67, 10'sd75, 10'sd83, 10'sd92, 10'sd102,
    10'sd114, 10'sd127, 10'sd143, 10'sd162, 10'sd192, 10'sd223, 10'sd252, 10'sd283};

  // mic codes step 3 dB from +12, saturate at +30
  always_comb begin
    gainValid  = 1'b1;
    gainTenths = LINE_TAB[code];
    if (mode == IPGAC_MODE_DMIC) begin
      if (code == 5'h00) begin
        gainValid  = 1'b0;   // reserved
        gainTenths = '0;
      end else if (code >= 5'h07) begin
        gainTenths = 10'sd300;
      end else begin
        gainTenths = 10'(90 + 30 * int'(code));
      end
    end else if (mode != IPGAC_MODE_SE && mode != IPGAC_MODE_DLIN) begin
      gainValid = 1'b0;   // reserved mode
    end
  end

endmodule

/* src/ipgac_pin_dec.sv */
// pin selector code to one-hot pin choice
`timescale 1ns/1ps
module ipgac_pin_dec
  import ipgac_pkg::*;
(
  // selector
  input  wire logic [1:0] sel,
  // one-hot pin a, b, c
  output ipgac_pin_t      pin
);

  // 1x picks the third pin
  always_comb begin
    if (sel[1]) begin
      pin = 3'h4;
    end else if (sel[0]) begin
      pin = 3'h2;
    end else begin
      pin = 3'h1;
    end
  end

endmodule

/* src/ipgac_regs.sv */
// input gain amplifier configuration registers with axi4-lite slave
//
// Summary of operation
// R01: right_amp_silence sits at bit 7, 1 mutes, 0 unmutes, resets to 1.
// R02: right_amp_gain is a 5-bit field at bits 4:0, line modes map -1.5 dB to +28.3 dB.
// R03: in mic mode right codes 1..6 give +12..+27 dB, 7 and up +30 dB, 0 reserved.
// R04: right_amp_gain resets to 00101, 0 dB in line modes and +24 dB in mic mode.
// R05: left_cm_reject_en at bit 6 resets to 1 and acts only in differential line mode.
// R06: left_neg_pin_sel at 5:4 resets to 00, inverting side in line modes, other in mic.
// R07: left_pos_pin_sel at 3:2 resets to 01, non-inverting side in line modes, swapped in mic.
// R08: left mode at 1:0 resets to 00: 00 single, 01 diff line, 10 diff mic, 11 reserved.
// R09: the right mode comes from its own 2-bit field with the same encoding.
// R10: software keeps reserved codes out; behaviour then is undefined.
`timescale 1ns/1ps
module ipgac_regs
  import ipgac_pkg::*;
#(
  parameter int ADDR_W = IPGAC_ADDR_W
)(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // analogue controls
  output ipgac_right_ctl_t       rightCtl,
  output ipgac_left_ctl_t        leftCtl,
  output logic [1:0]             rightMode
);

  // elaboration check
  if (ADDR_W < IPGAC_ADDR_W) begin : g_chk
    $error("ADDR_W too small for the register map");
  end

  // stored fields
  logic        rightSilence_r;
  logic [4:0]  rightGain_r;
  logic        leftCmReject_r;
  logic [1:0]  leftNegSel_r;
  logic [1:0]  leftPosSel_r;
  logic [1:0]  leftMode_r;
  logic [1:0]  rightMode_r;

  // write and read channel latches
  logic              awHeld_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic              wHeld_r;
  logic [31:0]       wData_r;
  logic [3:0]        wStrb_r;
  logic              bValid_r;
  logic [1:0]        bResp_r;
  logic              rValid_r;
  logic [1:0]        rResp_r;
  logic [31:0]       rData_r;

  logic        doWrite;
  logic        wrHit;
  logic [31:0] rdWord;
  logic        rdHit;

  // low-byte write strobes per register
  logic        wrRGain;
  logic        wrLRoute;
  logic        wrRMode;

  // field values that the coming edge stores
  logic [4:0]  rightGain_nxt;
  logic [1:0]  rightMode_nxt;
  logic        leftCmReject_nxt;
  logic [1:0]  leftNegSel_nxt;
  logic [1:0]  leftPosSel_nxt;
  logic [1:0]  leftMode_nxt;

  // decoded controls and their output flops
  ipgac_gain_t gainTenths_nxt;
  logic        gainValid_nxt;
  ipgac_gain_t gainTenths_r;
  logic        gainValid_r;
  ipgac_pin_t  negPin;
  ipgac_pin_t  posPin;
  ipgac_pin_t  invPin_nxt;
  ipgac_pin_t  nonPin_nxt;
  logic        cmRejectOn_nxt;
  ipgac_pin_t  invPin_r;
  ipgac_pin_t  nonPin_r;
  logic        cmRejectOn_r;

  // address and data accepted independently, one at a time
  assign s_axi_awready = !awHeld_r && !bValid_r;
  assign s_axi_wready  = !wHeld_r && !bValid_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  assign doWrite = awHeld_r && wHeld_r && !bValid_r;

  // write strobes, low byte lane only
  assign wrRGain  = doWrite && awAddr_r == IPGAC_ADDR_RGAIN && wStrb_r[0];
  assign wrLRoute = doWrite && awAddr_r == IPGAC_ADDR_LROUTE && wStrb_r[0];
  assign wrRMode  = doWrite && awAddr_r == IPGAC_ADDR_RMODE && wStrb_r[0];

  // next field values, so decoded outputs move on the same edge as the fields
  assign rightGain_nxt    = wrRGain ? wData_r[IPGAC_GAIN_LSB +: IPGAC_GAIN_W] : rightGain_r;
  assign rightMode_nxt    = wrRMode ? wData_r[IPGAC_MODE_LSB +: 2] : rightMode_r;
  assign leftCmReject_nxt = wrLRoute ? wData_r[IPGAC_CMR_BIT] : leftCmReject_r;
  assign leftNegSel_nxt   = wrLRoute ? wData_r[IPGAC_NSEL_LSB +: 2] : leftNegSel_r;
  assign leftPosSel_nxt   = wrLRoute ? wData_r[IPGAC_PSEL_LSB +: 2] : leftPosSel_r;
  assign leftMode_nxt     = wrLRoute ? wData_r[IPGAC_MODE_LSB +: 2] : leftMode_r;

  // write address hold
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_r <= 1'b1;
      awAddr_r <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_r <= 1'b0;
    end
  end

  // write data hold
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wHeld_r <= 1'b0;
      wData_r <= '0;
      wStrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_r <= 1'b1;
      wData_r <= s_axi_wdata;
      wStrb_r <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_r <= 1'b0;
    end
  end

  // address decode of writes
  always_comb begin
    case (awAddr_r)
      IPGAC_ADDR_RGAIN, IPGAC_ADDR_LROUTE, IPGAC_ADDR_RMODE: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // write response
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bValid_r <= 1'b0;
      bResp_r  <= IPGAC_RESP_OKAY;
    end else if (doWrite) begin
      bValid_r <= 1'b1;
      bResp_r  <= wrHit ? IPGAC_RESP_OKAY : IPGAC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_r <= 1'b0;
    end
  end

  // right gain and mute register, low byte lane only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rightSilence_r <= IPGAC_MUTE_RST;   // R01
      rightGain_r    <= IPGAC_GAIN_RST;   // R04
    end else if (wrRGain) begin
      rightSilence_r <= wData_r[IPGAC_MUTE_BIT];   // R01
      rightGain_r    <= wData_r[IPGAC_GAIN_LSB +: IPGAC_GAIN_W];   // R02
    end
  end

  // left routing and mode register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      leftCmReject_r <= IPGAC_CMR_RST;    // R05
      leftNegSel_r   <= IPGAC_NSEL_RST;   // R06
      leftPosSel_r   <= IPGAC_PSEL_RST;   // R07
      leftMode_r     <= IPGAC_MODE_RST;   // R08
    end else if (wrLRoute) begin
      leftCmReject_r <= wData_r[IPGAC_CMR_BIT];   // R05
      leftNegSel_r   <= wData_r[IPGAC_NSEL_LSB +: 2];   // R06
      leftPosSel_r   <= wData_r[IPGAC_PSEL_LSB +: 2];   // R07
      leftMode_r     <= wData_r[IPGAC_MODE_LSB +: 2];   // R08
    end
  end

  // right mode field, separate register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rightMode_r <= IPGAC_MODE_RST;   // R09
    end else if (wrRMode) begin
      rightMode_r <= wData_r[IPGAC_MODE_LSB +: 2];   // R09
    end
  end

  // read mux, unused bits read zero
  always_comb begin
    rdWord = '0;
    rdHit  = 1'b1;
    case (s_axi_araddr)
      IPGAC_ADDR_RGAIN: begin
        rdWord[IPGAC_MUTE_BIT]                     = rightSilence_r;
        rdWord[IPGAC_GAIN_LSB +: IPGAC_GAIN_W]     = rightGain_r;
      end
      IPGAC_ADDR_LROUTE: begin
        rdWord[IPGAC_CMR_BIT]          = leftCmReject_r;
        rdWord[IPGAC_NSEL_LSB +: 2]    = leftNegSel_r;
        rdWord[IPGAC_PSEL_LSB +: 2]    = leftPosSel_r;
        rdWord[IPGAC_MODE_LSB +: 2]    = leftMode_r;
      end
      IPGAC_ADDR_RMODE: begin
        rdWord[IPGAC_MODE_LSB +: 2]    = rightMode_r;
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  // read response, one cycle after address taken
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rValid_r <= 1'b0;
      rData_r  <= '0;
      rResp_r  <= IPGAC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_r <= 1'b1;
      rData_r  <= rdWord;
      rResp_r  <= rdHit ? IPGAC_RESP_OKAY : IPGAC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // right gain decode by right mode, on the values being stored
  ipgac_gain_map u_gain_map (
    .code       (rightGain_nxt),   // R03
    .mode       (rightMode_nxt),   // R09
    .gainTenths (gainTenths_nxt),
    .gainValid  (gainValid_nxt)
  );

  // left pin decode of the selectors being stored
  ipgac_pin_dec u_neg_dec (
    .sel (leftNegSel_nxt),
    .pin (negPin)
  );
  ipgac_pin_dec u_pos_dec (
    .sel (leftPosSel_nxt),
    .pin (posPin)
  );

  // sides swap in mic mode; cm rejection only in diff line
  always_comb begin
    if (leftMode_nxt == IPGAC_MODE_DMIC) begin
      invPin_nxt = posPin;   // R07
      nonPin_nxt = negPin;   // R06
    end else begin
      invPin_nxt = negPin;   // R06
      nonPin_nxt = posPin;   // R07
    end
    cmRejectOn_nxt = leftCmReject_nxt && (leftMode_nxt == IPGAC_MODE_DLIN);   // R05
  end

  // cm rejection flop, reset to the gate of the reset fields
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmRejectOn_r <= IPGAC_CMR_RST && (IPGAC_MODE_RST == IPGAC_MODE_DLIN);   // R05
    end else begin
      cmRejectOn_r <= cmRejectOn_nxt;   // R05
    end
  end

  // decoded gain and pins; no reset, they reload from the reset fields
  // at each edge inside reset, so rst_b must stay low across one edge
  always_ff @(posedge sys_clk) begin
    gainTenths_r <= gainTenths_nxt;   // R02 R03 R04
    gainValid_r  <= gainValid_nxt;
    invPin_r     <= invPin_nxt;   // R06 R07
    nonPin_r     <= nonPin_nxt;   // R06 R07
  end

  // output bundles, all from flip-flops
  assign rightCtl.silence    = rightSilence_r;   // R01
  assign rightCtl.gainTenths = gainTenths_r;
  assign rightCtl.gainValid  = gainValid_r;
  assign rightMode           = rightMode_r;   // R09
  assign leftCtl.invPin      = invPin_r;
  assign leftCtl.nonPin      = nonPin_r;
  assign leftCtl.cmRejectOn  = cmRejectOn_r;
  assign leftCtl.mode        = leftMode_r;   // R08

endmodule

/* test/ipgac_regs_assertions.sv */
// checker for the input gain config registers, bound to the register module
`timescale 1ns/1ps
module ipgac_chk
  import ipgac_pkg::*;
(
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             rst_b,
  // axi handshakes
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [1:0]       s_axi_bresp,
  // analogue controls
  input wire ipgac_right_ctl_t rightCtl,
  input wire ipgac_left_ctl_t  leftCtl,
  input wire logic [1:0]       rightMode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // read request taken, read answer waiting
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  // bus answers
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  a_rd_hold: assert property (s_rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  // values at release of reset
  a_mute_reset: assert property ($rose(rst_b) |-> rightCtl.silence && rightMode == 2'h0)
    else $error("right channel not muted after reset");
  a_gain_reset: assert property ($rose(rst_b) |->
    rightCtl.gainTenths == 0 && rightCtl.gainValid)
    else $error("right gain not at zero after reset");
  a_pin_reset: assert property ($rose(rst_b) |->
    leftCtl.invPin == 3'h1 && leftCtl.nonPin == 3'h2
    && leftCtl.mode == 2'h0 && !leftCtl.cmRejectOn)
    else $error("left routing wrong after reset");
  // decode ranges
  a_cm_gate: assert property (leftCtl.cmRejectOn |-> leftCtl.mode == 2'h1)
    else $error("cm rejection on outside diff line mode");
  a_line_span: assert property (rightMode < 2'h2 |-> rightCtl.gainValid
    && rightCtl.gainTenths >= -15 && rightCtl.gainTenths <= 283)
    else $error("line gain out of range");
  a_mic_span: assert property (rightMode == 2'h2 && rightCtl.gainValid
    |-> rightCtl.gainTenths >= 120 && rightCtl.gainTenths <= 300)
    else $error("mic gain out of range");
  a_pin_onehot: assert property ($onehot(leftCtl.invPin) && $onehot(leftCtl.nonPin))
    else $error("pin choice not one-hot");
endmodule

bind ipgac_regs ipgac_chk ipgac_chk_inst (.sys_clk, .rst_b, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .rightCtl, .leftCtl, .rightMode);

/* test/tb_top.sv */
// self-checking bench for the input gain config registers
`timescale 1ns/1ps
module tb_top
  import ipgac_pkg::*;
;
  logic             sys_clk, rst_b;
  logic [11:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata, d;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, rightMode;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready;
  ipgac_right_ctl_t rightCtl;
  ipgac_left_ctl_t  leftCtl;
  int               n_mismatch, n_checks, seed, m, g, k;
  logic [7:0]       mdl [3];
  logic [7:0]       msk [3] = '{8'h9f, 8'h7f, 8'h03};
  logic [11:0]      adr [3] = '{IPGAC_ADDR_RGAIN, IPGAC_ADDR_LROUTE, IPGAC_ADDR_RMODE};
  int               lineTab [32] = '{-15, -13, -10, -7, -3, 0, 3, 7, 10, 14, 18, 23, 27, 32,
    37, 42, 48, 54, 60, 67, 75, 83, 92, 102, 114, 127, 143, 162, 192, 223, 252, 283};

  ipgac_regs ipgac_regs_inst (.sys_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rightCtl, .leftCtl, .rightMode);

  // 125 MHz clock
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end

  // one compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // hung handshake
  task automatic hang();
    n_mismatch++;
    $display("ERROR %0t handshake timed out", $time);
    summarize();
  endtask

  function automatic int idx(input logic [11:0] a);
    for (int j = 0; j < 3; j++) if (a == adr[j]) return j;
    return -1;
  endfunction

  function automatic logic [2:0] pin(input logic [1:0] s);
    return s[1] ? 3'h4 : (s[0] ? 3'h2 : 3'h1);
  endfunction

  // analogue outputs against the model
  task automatic chkCtl();
    logic [4:0]  c;
    logic [1:0]  rm, lm;
    ipgac_gain_t eg;
    c = mdl[0][4:0];
    rm = mdl[2][1:0];
    lm = mdl[1][1:0];
    eg = (rm == 2'h2) ? ((c >= 7) ? 300 : 120 + 30 * (c - 1)) : lineTab[c];
    chk(rightCtl.silence, mdl[0][7]);
    chk(rightMode, rm);
    if (rm != 2'h2 || c != 0) begin
      chk(rightCtl.gainTenths, eg);
      chk(rightCtl.gainValid, 1'b1);
    end
    chk(leftCtl.invPin, pin(lm == 2'h2 ? mdl[1][3:2] : mdl[1][5:4]));
    chk(leftCtl.nonPin, pin(lm == 2'h2 ? mdl[1][5:4] : mdl[1][3:2]));
    chk(leftCtl.cmRejectOn, mdl[1][6] && lm == 2'h1);
    chk(leftCtl.mode, lm);
  endtask

  // axi4-lite write, address and data offered together
  task automatic axw(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    int i;
    int j;
    j = idx(a);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 40) hang();
    s_axi_bready <= 1'b0;
    if (j >= 0 && s[0]) mdl[j] = v[7:0] & msk[j];
    chk(s_axi_bresp, j < 0 ? IPGAC_RESP_SLVERR : IPGAC_RESP_OKAY);
    chkCtl();
  endtask

  // axi4-lite read
  task automatic axr(input logic [11:0] a);
    int i;
    int j;
    j = idx(a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 40) hang();
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, j < 0 ? 32'h0 : {24'h0, mdl[j]});
    chk(s_axi_rresp, j < 0 ? IPGAC_RESP_SLVERR : IPGAC_RESP_OKAY);
    chkCtl();
  endtask

  // reset pulse, then all registers read back
  task automatic rst(input int n);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (n) @(posedge sys_clk);
    rst_b <= 1'b1;
    mdl = '{8'h85, 8'h44, 8'h00};
    for (k = 0; k < 3; k++) axr(adr[k]);
  endtask

  // main sequence
  initial begin
    seed = 32'h9a3be7a5;
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    rst(20);
    axw(12'hc0, $random(seed), 4'hf);
    axr(12'hc0);
    axw(adr[0], 32'h0, 4'he);
    axr(adr[0]);
    // every allowed gain code in each mode, mute and spare bits random
    for (m = 0; m < 3; m++) begin
      axw(adr[2], m, 4'h1);
      for (g = 0; g < 32; g++) begin
        d = $random(seed);
        d[4:0] = g;
        if (m == 2 && g == 0) d[4:0] = 5'h01;
        axw(adr[0], d, 4'h1);
      end
      axr(adr[0]);
    end
    // random routing words and strobes
    repeat (60) begin
      d = $random(seed);
      if (d[1:0] == 2'h3) d[1:0] = 2'h2;
      axw(adr[1], d, 4'($random(seed)));
      axr(adr[1]);
    end
    rst(2);
    summarize();
  end
endmodule
